// File: hdl/sac_consts.vh
// Function
// - Sample selected input at full base rate
// - Channel source chosen among all inputs
// - One shot holds at most 64 kSa
// - Shot time is length times reduced period
// - Decimation keeps every Nth sample only
// - Averaging outputs mean of N samples
// - Averaging after reset, decimation selectable
// - Optional exponential average over shots
// - Trigger enabled: shot starts on trigger
// - Trigger disabled: shots back to back
// - Upgrade records two channels at once
// - Own source each, shared trigger/rate/length
// - Derived inputs scaled/offset into 12 bits
// - Scale and offset readable with data
// - Direct inputs: limits read-only, show range
// - Segmented burst stored on board
// - Segmented hold-off below 100 us
// - Segmented data carries segment number
// - Idle, buffer, armed, active, idle sequence
// - Gating lets trigger pass only when active
`ifndef SAC_CONSTS_VH
`define SAC_CONSTS_VH
// ==========================================
// Register offsets
`define SAC_ADR_CTRL 8'h00
`define SAC_ADR_SRC 8'h04
`define SAC_ADR_RATE 8'h08
`define SAC_ADR_LEN 8'h0C
`define SAC_ADR_PRE 8'h10
`define SAC_ADR_EMA 8'h14
`define SAC_ADR_SCALE 8'h18
`define SAC_ADR_OFFS 8'h1C
`define SAC_ADR_LIMLO 8'h20
`define SAC_ADR_LIMHI 8'h24
`define SAC_ADR_STAT 8'h28
`define SAC_ADR_RDADR 8'h2C
`define SAC_ADR_RDDAT 8'h30
`define SAC_ADR_SEGN 8'h34
`define SAC_ADR_START 8'h38
// ==========================================
// Control bit positions
`define SAC_B_RUN 0
`define SAC_B_TRIG 1
`define SAC_B_DECIM 2
`define SAC_B_DUAL 3
`define SAC_B_GATE 4
`define SAC_B_SEG 5
`define SAC_B_EMA 6
// ==========================================
// Reset values and limits
`define SAC_RST_CTRL 7'h00
`define SAC_RST_SRC 8'h10
`define SAC_RST_RATE 16'h0001
`define SAC_RST_LEN 17'h01000
`define SAC_MAX_LEN 17'h10000
`define SAC_RST_SCALE 16'h0100
`define SAC_SRC_DER 4'h7
// ==========================================
// Timing
`define SAC_CLK_NS 25
`define SAC_HOLDOFF_US 100
`define SAC_HOLDOFF_CYC ((`SAC_HOLDOFF_US * 1000) / `SAC_CLK_NS)
// ==========================================
// Acquisition states
`define SAC_ST_IDLE 2'h0
`define SAC_ST_BUF 2'h1
`define SAC_ST_ARM 2'h2
`define SAC_ST_ACT 2'h3
`endif

// File: hdl/sac_top.v
`timescale 1ns/10ps
`include "sac_consts.vh"
module sac_top (
    input wire clk_i, // System clock
    input wire rst_i, // Synchronous reset
    input wire wb_cyc_i, // Bus cycle
    input wire wb_stb_i, // Bus strobe
    input wire wb_we_i, // Write enable
    input wire [7:0] wb_adr_i, // Byte address
    input wire [3:0] wb_sel_i, // Byte lanes
    input wire [31:0] wb_dat_i, // Write data
    output reg [31:0] wb_dat_o, // Read data
    output reg wb_ack_o, // Acknowledge
    input wire smp_vld_i, // Full-rate sample strobe
    input wire [11:0] sig0_i, // Signal input 1
    input wire [11:0] sig1_i, // Signal input 2
    input wire [11:0] aux0_i, // Auxiliary input 1
    input wire [11:0] aux1_i, // Auxiliary input 2
    input wire [11:0] trg0_i, // Trigger input 1
    input wire [11:0] trg1_i, // Trigger input 2
    input wire [11:0] osc_i, // Oscillator phase
    input wire [15:0] der_i, // Derived signal, signed
    input wire [15:0] rng_lo_i, // Input range low limit
    input wire [15:0] rng_hi_i, // Input range high limit
    input wire trig_evt_i, // Trigger condition met
    input wire gate_i, // Trigger gate input
    output wire [1:0] state_o, // Acquisition state
    output wire [15:0] seg_o // Current segment
);

// ==========================================
// Helpers
function [31:0] merge;
    input [31:0] old;
    input [31:0] d;
    input [3:0] s;
    integer i;
    begin
        for (i = 0; i < 4; i = i + 1)
            merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
endfunction

function [11:0] sat12;
    input signed [31:0] v;
    begin
        if (v < 0)
            sat12 = 12'h000;
        else if (v > 32'sd4095)
            sat12 = 12'hFFF;
        else
            sat12 = v[11:0];
    end
endfunction

// ==========================================
// Register file
reg [6:0] ctrl_ff;
reg [7:0] src_ff;
reg [15:0] rate_ff;
reg [16:0] len_ff;
reg [15:0] pre_ff;
reg [3:0] emad_ff;
reg [15:0] scale_ff;
reg [15:0] offs_ff;
reg [15:0] limlo_ff;
reg [15:0] limhi_ff;
reg [15:0] segn_ff;
reg [16:0] rdadr_ff;
reg [1:0] st_ff;
reg [15:0] seg_ff;
reg [15:0] start_ff;
wire [11:0] rd_w [0:1];

wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wb_wr = wb_req & wb_we_i;
wire [31:0] wd_ctrl = merge({25'h0, ctrl_ff}, wb_dat_i, wb_sel_i);
wire [31:0] wd_src = merge({24'h0, src_ff}, wb_dat_i, wb_sel_i);
wire [31:0] wd_rate = merge({16'h0, rate_ff}, wb_dat_i, wb_sel_i);
wire [31:0] wd_len = merge({15'h0, len_ff}, wb_dat_i, wb_sel_i);
wire [31:0] wd_pre = merge({16'h0, pre_ff}, wb_dat_i, wb_sel_i);
wire [31:0] wd_ema = merge({28'h0, emad_ff}, wb_dat_i, wb_sel_i);
wire [31:0] wd_scl = merge({16'h0, scale_ff}, wb_dat_i, wb_sel_i);
wire [31:0] wd_ofs = merge({16'h0, offs_ff}, wb_dat_i, wb_sel_i);
wire [31:0] wd_llo = merge({16'h0, limlo_ff}, wb_dat_i, wb_sel_i);
wire [31:0] wd_lhi = merge({16'h0, limhi_ff}, wb_dat_i, wb_sel_i);
wire [31:0] wd_segn = merge({16'h0, segn_ff}, wb_dat_i, wb_sel_i);
wire [31:0] wd_rda = merge({15'h0, rdadr_ff}, wb_dat_i, wb_sel_i);

// Software-written settings
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        ctrl_ff <= `SAC_RST_CTRL; // Averaging reduction by default
        src_ff <= `SAC_RST_SRC;
        rate_ff <= `SAC_RST_RATE;
        len_ff <= `SAC_RST_LEN;
        pre_ff <= 16'h0000;
        emad_ff <= 4'h0;
        scale_ff <= `SAC_RST_SCALE;
        offs_ff <= 16'h0000;
        limlo_ff <= 16'h0000;
        limhi_ff <= 16'h0FFF;
        segn_ff <= 16'h0001;
        rdadr_ff <= 17'h00000;
    end
    else if (wb_wr)
    begin
        case (wb_adr_i)
            `SAC_ADR_CTRL: ctrl_ff <= wd_ctrl[6:0]; // Decimation switch
            `SAC_ADR_SRC: src_ff <= wd_src[7:0]; // Per-channel source
            `SAC_ADR_RATE: rate_ff <= wd_rate[15:0];
            // Shot length capped at 64 kSa
            `SAC_ADR_LEN: len_ff <= (wd_len > {15'h0, `SAC_MAX_LEN}) ?
                `SAC_MAX_LEN : wd_len[16:0];
            `SAC_ADR_PRE: pre_ff <= wd_pre[15:0];
            `SAC_ADR_EMA: emad_ff <= wd_ema[3:0]; // Averaging depth
            `SAC_ADR_SCALE: scale_ff <= wd_scl[15:0];
            `SAC_ADR_OFFS: offs_ff <= wd_ofs[15:0];
            `SAC_ADR_LIMLO: limlo_ff <= wd_llo[15:0];
            `SAC_ADR_LIMHI: limhi_ff <= wd_lhi[15:0];
            `SAC_ADR_SEGN: segn_ff <= wd_segn[15:0];
            `SAC_ADR_RDADR: rdadr_ff <= wd_rda[16:0];
            default: ;
        endcase
    end
end

wire run = ctrl_ff[`SAC_B_RUN];
wire trig_en = ctrl_ff[`SAC_B_TRIG];
wire decim = ctrl_ff[`SAC_B_DECIM];
wire dual = ctrl_ff[`SAC_B_DUAL];
wire gate_en = ctrl_ff[`SAC_B_GATE];
wire seg_en = ctrl_ff[`SAC_B_SEG];
wire [15:0] nfac = (rate_ff == 16'h0000) ? 16'h0001 : rate_ff;
wire [16:0] len_e = (len_ff == 17'h00000) ? 17'h00001 : len_ff;
wire [15:0] segn_e = (segn_ff == 16'h0000) ? 16'h0001 : segn_ff;

// Limits reflect the input range for direct sources
wire direct0 = (src_ff[3:0] != `SAC_SRC_DER);
wire [15:0] lim_lo = direct0 ? rng_lo_i : limlo_ff;
wire [15:0] lim_hi = direct0 ? rng_hi_i : limhi_ff;

// Sample's segment, derived from its address in the burst
wire [16:0] rd_seg = {1'b0, rdadr_ff[15:0]} / len_e;

// Read mux
reg [31:0] rd_mux;
always @*
begin
    case (wb_adr_i)
        `SAC_ADR_CTRL: rd_mux = {25'h0, ctrl_ff};
        `SAC_ADR_SRC: rd_mux = {24'h0, src_ff};
        `SAC_ADR_RATE: rd_mux = {16'h0, rate_ff};
        `SAC_ADR_LEN: rd_mux = {15'h0, len_ff};
        `SAC_ADR_PRE: rd_mux = {16'h0, pre_ff};
        `SAC_ADR_EMA: rd_mux = {28'h0, emad_ff};
        `SAC_ADR_SCALE: rd_mux = {16'h0, scale_ff};
        `SAC_ADR_OFFS: rd_mux = {16'h0, offs_ff};
        `SAC_ADR_LIMLO: rd_mux = {16'h0, lim_lo};
        `SAC_ADR_LIMHI: rd_mux = {16'h0, lim_hi};
        `SAC_ADR_STAT: rd_mux = {seg_ff, 14'h0, st_ff};
        `SAC_ADR_RDADR: rd_mux = {15'h0, rdadr_ff};
        `SAC_ADR_RDDAT: rd_mux = {rd_seg[15:0], 4'h0, rd_w[rdadr_ff[16]]};
        `SAC_ADR_SEGN: rd_mux = {16'h0, segn_ff};
        `SAC_ADR_START: rd_mux = {16'h0, start_ff};
        default: rd_mux = 32'h00000000;
    endcase
end

// Bus answer, one cycle after the request
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
    end
    else
    begin
        wb_ack_o <= wb_req;
        if (wb_req & ~wb_we_i)
            wb_dat_o <= rd_mux;
    end
end

// ==========================================
// Derived input scaling into 12-bit codes
wire signed [31:0] der_prod = $signed(der_i) * $signed({1'b0, scale_ff});
wire signed [31:0] der_sum = (der_prod >>> 8) + $signed({{16{offs_ff[15]}}, offs_ff});
wire [11:0] der_code = sat12(der_sum);

// ==========================================
// Shared rate reduction counter
reg [15:0] red_cnt_ff;
reg rvld_ff;
wire red_last = (red_cnt_ff == nfac - 16'h0001);

// Every full-rate sample enters the reducer
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        red_cnt_ff <= 16'h0000;
        rvld_ff <= 1'b0;
    end
    else
    begin
        rvld_ff <= smp_vld_i & red_last;
        if (smp_vld_i)
            red_cnt_ff <= red_last ? 16'h0000 : red_cnt_ff + 16'h0001;
    end
end

// ==========================================
// Shot sequencer
reg [15:0] wptr_ff;
reg [16:0] cnt_ff;
reg [15:0] shots_ff;
wire wr_en = rvld_ff & (st_ff != `SAC_ST_IDLE);
wire [15:0] wp_inc = ({1'b0, wptr_ff} + 17'h00001 >= len_e) ?
    16'h0000 : wptr_ff + 16'h0001;
wire [31:0] base_w = seg_ff * len_e[15:0];
wire [15:0] waddr = base_w[15:0] + wptr_ff;
wire trig_ok = trig_evt_i & (~gate_en | gate_i);
wire [16:0] cnt_inc = cnt_ff + 17'h00001;
wire [16:0] st_diff = {1'b0, wptr_ff} + len_e - {1'b0, pre_ff};
wire [16:0] st_pos = (wptr_ff >= pre_ff) ? {1'b0, wptr_ff - pre_ff} :
    st_diff;

// State sequence of each shot
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        st_ff <= `SAC_ST_IDLE;
        wptr_ff <= 16'h0000;
        cnt_ff <= 17'h00000;
        seg_ff <= 16'h0000;
        start_ff <= 16'h0000;
        shots_ff <= 16'h0000;
    end
    else
    begin
        if (wr_en)
            wptr_ff <= wp_inc;
        if (~ctrl_ff[`SAC_B_EMA])
            shots_ff <= 16'h0000;
        case (st_ff)
            `SAC_ST_IDLE:
            begin
                cnt_ff <= 17'h00000;
                wptr_ff <= 16'h0000;
                if (run)
                    st_ff <= `SAC_ST_BUF; // Continuous rearm
            end
            `SAC_ST_BUF:
            begin
                // Gather pre-trigger samples
                if (pre_ff == 16'h0000)
                    st_ff <= `SAC_ST_ARM;
                else if (wr_en)
                begin
                    cnt_ff <= cnt_inc;
                    if (cnt_inc >= {1'b0, pre_ff})
                        st_ff <= `SAC_ST_ARM;
                end
            end
            `SAC_ST_ARM:
            begin
                // Wait for an accepted trigger, or pass straight through
                if (~trig_en | trig_ok)
                begin
                    st_ff <= `SAC_ST_ACT;
                    cnt_ff <= {1'b0, pre_ff};
                    start_ff <= st_pos[15:0];
                end
            end
            `SAC_ST_ACT:
            begin
                // Record until the shot length is complete
                if (wr_en)
                begin
                    cnt_ff <= cnt_inc;
                    if (cnt_inc >= len_e)
                    begin
                        shots_ff <= shots_ff + 16'h0001;
                        // Next segment starts at once, no host wait
                        if (seg_en & (seg_ff + 16'h0001 < segn_e))
                        begin
                            seg_ff <= seg_ff + 16'h0001;
                            st_ff <= `SAC_ST_BUF;
                            cnt_ff <= 17'h00000;
                            wptr_ff <= 16'h0000;
                        end
                        else
                        begin
                            seg_ff <= 16'h0000;
                            st_ff <= `SAC_ST_IDLE;
                        end
                    end
                end
            end
            default: st_ff <= `SAC_ST_IDLE;
        endcase
    end
end

assign state_o = st_ff;
assign seg_o = seg_ff;

// Shot averaging active only after a first complete shot
wire ema_act = ctrl_ff[`SAC_B_EMA] & ~seg_en & (shots_ff != 16'h0000);

// ==========================================
// Channel datapaths: channel 1 only with the upgrade
genvar g;
generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_ch
        wire [3:0] sel = (g == 0) ? src_ff[3:0] : src_ff[7:4];
        reg [11:0] smp;
        reg [27:0] acc_ff;
        reg [11:0] red_ff;
        reg [11:0] rd_ff;
        reg [11:0] mem [0:65535];
        wire [27:0] acc_sum = acc_ff + {16'h0, smp};
        wire [27:0] mean = acc_sum / {12'h0, nfac};
        wire [11:0] old = mem[waddr];
        wire signed [12:0] diff = $signed({1'b0, red_ff}) - $signed({1'b0, old});
        wire signed [12:0] step = diff >>> emad_ff;
        wire [12:0] ema_sum = {1'b0, old} + step;
        wire [11:0] wdat = ema_act ? ema_sum[11:0] : red_ff;

        // Source selection
        always @*
        begin
            case (sel)
                4'h0: smp = sig0_i;
                4'h1: smp = sig1_i;
                4'h2: smp = aux0_i;
                4'h3: smp = aux1_i;
                4'h4: smp = trg0_i;
                4'h5: smp = trg1_i;
                4'h6: smp = osc_i;
                default: smp = der_code;
            endcase
        end

        // Rate reduction by decimation or averaging
        always @(posedge clk_i)
        begin
            if (rst_i)
            begin
                acc_ff <= 28'h0000000;
                red_ff <= 12'h000;
            end
            else if (smp_vld_i)
            begin
                if (red_last)
                begin
                    acc_ff <= 28'h0000000;
                    red_ff <= decim ? smp : mean[11:0];
                end
                else
                    acc_ff <= acc_sum;
            end
        end

        // Shot memory with registered host read port
        always @(posedge clk_i)
        begin
            if (wr_en & ((g == 0) | dual)) // Shared rate and length
                mem[waddr] <= wdat;
            rd_ff <= mem[rdadr_ff[15:0]];
        end
        assign rd_w[g] = rd_ff;
    end
endgenerate

endmodule // sac_top

// File: testbench/sac_properties.sv
`timescale 1ns/10ps
`include "sac_consts.vh"
// ==========================================
// Port checker
module sac_props (
    input wire clk_i, // Clock
    input wire rst_i, // Reset
    input wire wb_cyc_i, // Bus cycle
    input wire wb_stb_i, // Bus strobe
    input wire wb_we_i, // Write enable
    input wire [7:0] wb_adr_i, // Address
    input wire [3:0] wb_sel_i, // Lanes
    input wire [31:0] wb_dat_i, // Write data
    input wire wb_ack_o, // Acknowledge
    input wire trig_evt_i, // Trigger
    input wire gate_i, // Gate
    input wire [1:0] state_o // State
);
    reg [6:0] ctl_ff;
    wire req = wb_cyc_i & wb_stb_i;
    wire trg = trig_evt_i & (~ctl_ff[`SAC_B_GATE] | gate_i);
    // Shadow of the control register
    always @(posedge clk_i)
    begin
        if (rst_i)
            ctl_ff <= `SAC_RST_CTRL;
        else if (req && !wb_ack_o && wb_we_i && wb_adr_i == `SAC_ADR_CTRL && wb_sel_i[0])
            ctl_ff <= wb_dat_i[6:0];
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_after_take: assert property (s_take |=> s_pulse)
        else $error("ack missing");
    a_ack_needs_req: assert property (wb_ack_o |-> $past(req))
        else $error("ack without request");
    a_reset_idle: assert property ($fell(rst_i) |-> state_o == `SAC_ST_IDLE)
        else $error("not idle after reset");
    a_idle_run: assert property (state_o == `SAC_ST_IDLE && ctl_ff[0] |=> state_o == `SAC_ST_BUF)
        else $error("run did not start buffer");
    a_idle_next: assert property (state_o == `SAC_ST_IDLE |=> state_o inside {0, 1})
        else $error("bad exit from idle");
    a_buf_next: assert property (state_o == `SAC_ST_BUF |=> state_o inside {1, 2})
        else $error("bad exit from buffer");
    a_arm_hold: assert property (state_o == 2 && ctl_ff[1] && !trg |=> state_o == 2)
        else $error("armed left without trigger");
    a_arm_fire: assert property (state_o == 2 && ctl_ff[1] && trg |=> state_o == 3)
        else $error("trigger not taken");
    a_arm_pass: assert property (state_o == 2 && !ctl_ff[1] |=> state_o == 3)
        else $error("armed not passed");
    a_act_next: assert property (state_o == 3 |=> state_o != 2)
        else $error("active went to armed");
endmodule // sac_props
bind sac_top sac_props chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .trig_evt_i(trig_evt_i), .gate_i(gate_i),
    .state_o(state_o));

// File: testbench/sac_host.sv
`timescale 1ns/10ps
// ==========================================
// Host computer: classic bus master
module sac_host (
    input wire clk_i, // Clock
    input wire [31:0] dat_i, // Read data
    input wire ack_i, // Acknowledge
    output reg cyc_o, // Cycle
    output reg stb_o, // Strobe
    output reg we_o, // Write enable
    output reg [7:0] adr_o, // Address
    output reg [3:0] sel_o, // Lanes
    output reg [31:0] dat_o, // Write data
    output reg to_o // Wait ran out
);
    initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o, to_o} = 0;
    // One transfer, held until ack, then released with scrambled lines
    task xfer(input we, input [7:0] adr, input [31:0] wd, output [31:0] rd);
        integer n;
        begin
            n = 0;
            @(posedge clk_i);
            {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, we, adr, 4'hF, wd};
            @(posedge clk_i);
            while (!ack_i && n < 64)
            begin
                @(posedge clk_i);
                n = n + 1;
            end
            rd = dat_i;
            to_o <= !ack_i;
            {cyc_o, stb_o, adr_o, dat_o} <= {2'b00, ~adr, ~wd};
        end
    endtask
endmodule // sac_host

// File: testbench/tb_top.sv
`timescale 1ns/10ps
`include "sac_consts.vh"
// ==========================================
// Bench top
module tb_top;
    reg clk_i = 0, rst_i = 1, smp_vld_i = 0, trig_evt_i = 0, gate_i = 0;
    reg [11:0] s0 = 0, s1 = 0, a0 = 0, a1 = 0, t0 = 0, t1 = 0, os = 0;
    reg [15:0] der = 0, rlo = 16'h0123, rhi = 16'h0F21;
    wire cyc, stb, we, ack, to;
    wire [7:0] adr;
    wire [3:0] sel;
    wire [31:0] wd, rdat;
    wire [1:0] state_o;
    wire [15:0] seg;
    integer fail_count = 0, n_tests = 0, m, i, j, nr, sum, st, k = 0;
    reg [32:0] exp_q[$];
    reg [32:0] e;
    reg [31:0] x = 32'haa45e7fc, rd;
    reg [11:0] smp[0:15];
    reg [31:0] xv[0:15];
    always #12.5 clk_i = ~clk_i;
    sac_host host_u (.clk_i(clk_i), .dat_i(rdat), .ack_i(ack), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd), .to_o(to));
    sac_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
        .smp_vld_i(smp_vld_i), .sig0_i(s0), .sig1_i(s1), .aux0_i(a0), .aux1_i(a1),
        .trg0_i(t0), .trg1_i(t1), .osc_i(os), .der_i(der), .rng_lo_i(rlo), .rng_hi_i(rhi),
        .trig_evt_i(trig_evt_i), .gate_i(gate_i), .state_o(state_o), .seg_o(seg));
    function [31:0] xs(input [31:0] v);
        reg [31:0] t;
        begin
            t = v ^ (v << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    task check(input [31:0] seen, input [31:0] want);
        begin
            n_tests = n_tests + 1;
            if (seen !== want)
            begin
                $display("unexpected at %0t: got %h want %h", $time, seen, want);
                fail_count = fail_count + 1;
            end
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d errors %0d", n_tests, fail_count);
            if (fail_count == 0 && n_tests > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        host_u.xfer(1'b1, a, d, rd);
    endtask
    // Note the expected read value, then read
    task rdx(input [7:0] a, input [31:0] d, input care);
        begin
            exp_q.push_back({~care, d});
            host_u.xfer(1'b0, a, 32'h0, rd);
        end
    endtask
    task wait_st(input [1:0] s);
        begin
            j = 0;
            while (state_o !== s && j < 2000)
            begin
                @(posedge clk_i);
                j = j + 1;
            end
            if (state_o !== s)
            begin
                fail_count = fail_count + 1;
                stop_test;
            end
        end
    endtask
    // Random samples on every source, sig0 kept for expectations
    task feed(input integer n);
        begin
            for (i = 0; i < n; i = i + 1)
            begin
                @(posedge clk_i);
                x = xs(x);
                smp[i] = x[11:0];
                xv[k + i] = x;
                {s1, a0, a1} <= {x[23:12], x[31:20], x[19:8]};
                {s0, t0, t1, os, der, smp_vld_i} <= {x[11:0], x[15:4], x[27:16], x[30:19], x[15:0], 1'b1};
            end
            @(posedge clk_i);
            smp_vld_i <= 1'b0;
        end
    endtask
    // Oldest note against each read answer
    always @(posedge clk_i)
    begin
        if (ack && cyc && !we)
        begin
            e = exp_q.pop_front();
            if (!e[32])
                check(rdat, e[31:0]);
        end
        if (to)
        begin
            fail_count = fail_count + 1;
            stop_test;
        end
    end
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rdx(`SAC_ADR_CTRL, 32'h0, 1);
        rdx(`SAC_ADR_SRC, 32'h10, 1);
        rdx(`SAC_ADR_RATE, 32'h1, 1);
        rdx(`SAC_ADR_LEN, 32'h1000, 1);
        rdx(`SAC_ADR_SCALE, 32'h100, 1);
        rdx(8'h3C, 32'h0, 1);
        wr(`SAC_ADR_LEN, 32'h20000);
        rdx(`SAC_ADR_LEN, 32'h10000, 1);
        wr(`SAC_ADR_LIMLO, 32'h5555);
        rdx(`SAC_ADR_LIMLO, {16'h0, rlo}, 1);
        rdx(`SAC_ADR_LIMHI, {16'h0, rhi}, 1);
        wr(`SAC_ADR_OFFS, 32'h12);
        rdx(`SAC_ADR_OFFS, 32'h12, 1);
        wr(`SAC_ADR_LEN, 32'h4);
        wr(`SAC_ADR_PRE, 32'h0);
        // One shot of four samples each: averaging by 4, decimation by 4, then rate 1
        for (m = 0; m < 3; m = m + 1)
        begin
            nr = (m == 2) ? 1 : 4;
            wr(`SAC_ADR_RATE, nr);
            wr(`SAC_ADR_CTRL, 32'h1 | ((m == 1) << 2));
            wait_st(`SAC_ST_ACT);
            feed(4 * nr);
            wait_st(`SAC_ST_IDLE);
            wr(`SAC_ADR_CTRL, (m == 1) << 2);
            rdx(`SAC_ADR_START, 32'h0, 1);
            st = rd[15:0];
            for (j = 0; j < 4; j = j + 1)
            begin
                sum = 0;
                for (i = 0; i < nr; i = i + 1)
                    sum = sum + smp[j * nr + i];
                if (m == 1)
                    sum = smp[j * nr + nr - 1] * nr;
                wr(`SAC_ADR_RDADR, (st + j) % 4);
                rdx(`SAC_ADR_RDDAT, sum / nr, 1);
            end
        end
        // Trigger held off by the gate, then let through
        feed(4);
        wait_st(`SAC_ST_IDLE);
        trig_evt_i <= 1'b1;
        wr(`SAC_ADR_CTRL, 32'h13);
        wait_st(`SAC_ST_ARM);
        repeat (4) @(posedge clk_i);
        rdx(`SAC_ADR_STAT, 32'h2, 1);
        gate_i <= 1'b1;
        wait_st(`SAC_ST_ACT);
        rdx(`SAC_ADR_STAT, 32'h3, 1);
        // Segmented dual burst: sig1 on channel 0, derived on channel 1
        wr(`SAC_ADR_SRC, 32'h71);
        wr(`SAC_ADR_SEGN, 32'h2);
        wr(`SAC_ADR_CTRL, 32'h29);
        feed(4);
        wait_st(`SAC_ST_BUF);
        wait_st(`SAC_ST_ACT);
        check(seg, 32'h1);
        k = 4;
        feed(4);
        wait_st(`SAC_ST_IDLE);
        check(seg, 32'h0);
        // Both channels of both segments, segment number in the top half
        for (j = 0; j < 16; j = j + 1)
        begin
            i = j % 8;
            sum = $signed(xv[i][15:0]) + 32'sh12;
            if (sum < 0)
                sum = 0;
            if (sum > 4095)
                sum = 4095;
            if (j < 8)
                sum = xv[i][23:12];
            wr(`SAC_ADR_RDADR, (j / 8) * 32'h10000 + i);
            rdx(`SAC_ADR_RDDAT, (i / 4) * 32'h10000 + sum, 1);
        end
        stop_test;
    end
endmodule // tb_top
